// File: rtl/system_bus_arbitration_control.sv
// Bus arbitration control: init, stall, priority request, debug, clocks
`timescale 1ns/1ps
// Functional notes
// - Drive-enabled agent asserts bus init on a fatal bus condition.
// - Observed bus init resets lock activity and request arbitration.
// - Bus init leaves in-order queue and tracking state untouched.
// - After bus init, re-arbitrate and finish pending queue entries.
// - Full agent asserts block-next-request; owner issues nothing meanwhile.
// - Monitor outputs show breakpoint and performance counter status.
// - One monitor line serves as probe-ready output.
// - Another monitor line serves as probe-request input from debug tools.
// - Priority request active stops new requests except locked ones.
// - Drive bus request output whenever bus ownership is needed.
// - Sample bus request pin at power-on: asserted sets agent ID zero, deasserted the other ID.
// - Frequency select picks 100 MHz bus clock, 400 MHz system bus.
// - Bus init line is both observed and driven.
// - Capture power-on settings when reset goes inactive.
module system_bus_arbitration_control
	import bus_arb_pkg::*;
#(
	parameter logic [1:0] FREQ_CODE = FREQ_SEL_100MHZ,
	parameter int MON_W = 4
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Power-on straps
	input wire logic init_drv_strap_in,
	input wire logic init_obs_strap_in,
	// Bus init line, open drain, active high here
	input wire logic bus_init_line_in,
	output logic bus_init_line_out,
	output logic bus_init_line_oe_out,
	// Block next request, open drain
	input wire logic block_next_request_in,
	output logic block_next_request_out,
	output logic block_next_request_oe_out,
	// Priority request from priority agent
	input wire logic priority_bus_request_in,
	// Bus request, sampled at reset as strap
	input wire logic bus_request_in,
	output logic bus_request_out,
	output logic bus_request_oe_out,
	// Monitor status from core
	input wire logic [MON_W-1:0] mon_status_in,
	output logic [MON_W-1:0] breakpoint_monitor_lines_out,
	output logic probe_ready_out,
	input wire logic probe_request_in,
	output logic debug_req_out,
	// New transaction issue grant toward core
	output logic issue_ok_out,
	output logic [1:0] clock_freq_select_out,
	output logic [1:0] agent_id_out,
	output logic irq_out
);
	arb_state_t state_r, state_nxt;
	logic [4:0] ctrl_r;
	logic init_drv_en, init_obs_en;
	logic [1:0] agent_id;
	logic [EV_WIDTH-1:0] ev_status, ev_mask;
	logic irq;
	logic init_prev_r, pri_prev_r, probe_request_prev_r;
	logic init_pend_r;

	por_capture u_por (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.init_drv_strap_in(init_drv_strap_in),
		.init_obs_strap_in(init_obs_strap_in),
		.bus_req_strap_in(bus_request_in),
		.init_drv_en_out(init_drv_en),
		.init_obs_en_out(init_obs_en),
		.agent_id_out(agent_id)
	);

	// Register decode
	wire wr_ctrl = reg_wr_in && (reg_addr_in == REG_CTRL);
	wire wr_mask = reg_wr_in && (reg_addr_in == REG_IRQ_MASK);
	wire rd_stat = reg_rd_in && (reg_addr_in == REG_IRQ_STAT);

	// Observed conditions
	wire init_seen = bus_init_line_in && init_obs_en;
	wire stall = block_next_request_in;
	wire need_bus = ctrl_r[CTRL_NEED_BUS];
	wire locked = ctrl_r[CTRL_LOCKED];
	// Priority agent blocks new requests unless locked sequence
	wire pri_block = priority_bus_request_in && !locked;
	wire issue_ok = (state_r == ARB_OWN) && !stall && !pri_block
		&& !init_seen;

	// Event pulses
	wire [EV_WIDTH-1:0] events = {
		probe_request_in && !probe_request_prev_r,
		priority_bus_request_in && !pri_prev_r,
		init_seen && !init_prev_r
	};

	event_irq #(.W(EV_WIDTH)) u_irq (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.event_in(events),
		.clear_in(rd_stat),
		.mask_we_in(wr_mask),
		.mask_in(reg_wdata_in[EV_WIDTH-1:0]),
		.status_out(ev_status),
		.mask_out(ev_mask),
		.irq_out(irq)
	);

	// Arbitration state machine; bus init returns it to idle
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ARB_IDLE: begin
				if (need_bus || init_pend_r)
					state_nxt = ARB_REQ;
			end
			ARB_REQ: begin
				if (!pri_block)
					state_nxt = ARB_OWN;
			end
			ARB_OWN: begin
				if (pri_block)
					state_nxt = ARB_HOLD;
				else if (!need_bus && !init_pend_r)
					state_nxt = ARB_IDLE;
			end
			ARB_HOLD: begin
				if (!priority_bus_request_in)
					state_nxt = ARB_REQ;
			end
			default: state_nxt = ARB_IDLE;
		endcase
		if (init_seen)
			state_nxt = ARB_IDLE;
	end

	// Control and arbitration registers
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			state_r <= ARB_IDLE;
			ctrl_r <= CTRL_RESET;
			init_pend_r <= 1'b0;
			init_prev_r <= 1'b0;
			pri_prev_r <= 1'b0;
			probe_request_prev_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			init_prev_r <= init_seen;
			pri_prev_r <= priority_bus_request_in;
			probe_request_prev_r <= probe_request_in;
			if (wr_ctrl)
				ctrl_r <= reg_wdata_in[4:0];
			// Bus init clears lock, keeps queue state outside block
			if (init_seen)
				ctrl_r[CTRL_LOCKED] <= 1'b0;
			// Remember to re-arbitrate after bus init
			if (init_seen && !init_prev_r)
				init_pend_r <= 1'b1;
			else if (state_r == ARB_OWN && !need_bus)
				init_pend_r <= 1'b0;
		end
	end

	// Pin and status outputs, all registered
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			bus_init_line_out <= 1'b0;
			bus_init_line_oe_out <= 1'b0;
			block_next_request_out <= 1'b0;
			block_next_request_oe_out <= 1'b0;
			bus_request_out <= 1'b0;
			bus_request_oe_out <= 1'b0;
			breakpoint_monitor_lines_out <= '0;
			probe_ready_out <= 1'b0;
			debug_req_out <= 1'b0;
			issue_ok_out <= 1'b0;
			clock_freq_select_out <= FREQ_CODE;
			agent_id_out <= AGENT_ID_ZERO;
			irq_out <= 1'b0;
		end else begin
			// Drive bus init on fault when enabled
			bus_init_line_out <= ctrl_r[CTRL_FAULT] && init_drv_en;
			bus_init_line_oe_out <= ctrl_r[CTRL_FAULT] && init_drv_en;
			block_next_request_out <= ctrl_r[CTRL_STALL];
			block_next_request_oe_out <= ctrl_r[CTRL_STALL];
			bus_request_out <= state_nxt != ARB_IDLE;
			bus_request_oe_out <= state_nxt != ARB_IDLE;
			breakpoint_monitor_lines_out <= mon_status_in;
			probe_ready_out <= ctrl_r[CTRL_PROBE_RDY];
			debug_req_out <= probe_request_in;
			issue_ok_out <= issue_ok;
			clock_freq_select_out <= FREQ_CODE;
			agent_id_out <= agent_id;
			irq_out <= irq;
		end
	end

	// Read mux
	logic [31:0] rdata;
	always_comb begin
		rdata = ZERO_WORD;
		case (reg_addr_in)
			REG_CTRL: rdata[4:0] = ctrl_r;
			REG_STATUS: rdata[5:0] = {agent_id, init_obs_en, init_drv_en,
				state_r};
			REG_IRQ_STAT: rdata[EV_WIDTH-1:0] = ev_status;
			REG_IRQ_MASK: rdata[EV_WIDTH-1:0] = ev_mask;
			REG_MONITOR: rdata[MON_W-1:0] = mon_status_in;
			REG_CONFIG: rdata[1:0] = FREQ_CODE;
			default: rdata = ZERO_WORD;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in)
			reg_rdata_out <= ZERO_WORD;
		else
			reg_rdata_out <= reg_rd_in ? rdata : ZERO_WORD;
	end
endmodule

// File: rtl/bus_arb_pkg.sv
// Package with constants for the system bus arbitration control block
package bus_arb_pkg;
	// Frequency select code for 100 MHz bus clock (code chosen, table absent)
	localparam logic [1:0] FREQ_SEL_100MHZ = 2'h1;
	// Bus clock and system bus rates
	localparam int BUS_CLK_MHZ = 100;
	localparam int SYS_BUS_MHZ = 400;
	// Agent ID zero taken when the sampled request pin is asserted, the other ID when it is not
	localparam logic [1:0] AGENT_ID_ZERO = 2'h0;
	localparam logic [1:0] AGENT_ID_OTHER = 2'h1;
	// Register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_IRQ_STAT = 4'h2;
	localparam logic [3:0] REG_IRQ_MASK = 4'h3;
	localparam logic [3:0] REG_MONITOR = 4'h4;
	localparam logic [3:0] REG_CONFIG = 4'h5;
	// Control register fields
	localparam int CTRL_NEED_BUS = 0;
	localparam int CTRL_LOCKED = 1;
	localparam int CTRL_FAULT = 2;
	localparam int CTRL_STALL = 3;
	localparam int CTRL_PROBE_RDY = 4;
	// Interrupt event bits
	localparam int EV_INIT_SEEN = 0;
	localparam int EV_PRI_SEEN = 1;
	localparam int EV_PROBE_REQ = 2;
	localparam int EV_WIDTH = 3;
	// Reset values
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [3:0] MON_RESET = 4'h0;
	localparam logic [2:0] EV_RESET = 3'h0;
	// Arbitration states
	typedef enum logic [1:0] {
		ARB_IDLE = 2'b00,
		ARB_REQ = 2'b01,
		ARB_OWN = 2'b10,
		ARB_HOLD = 2'b11
	} arb_state_t;
endpackage

// File: rtl/por_capture.sv
// Power-on configuration capture at reset release
`timescale 1ns/1ps
module por_capture
	import bus_arb_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic init_drv_strap_in,
	input wire logic init_obs_strap_in,
	input wire logic bus_req_strap_in,
	output logic init_drv_en_out,
	output logic init_obs_en_out,
	output logic [1:0] agent_id_out
);
	logic rst_seen_r;
	// Latch straps in the first cycle after reset goes inactive
	always_ff @(posedge ref_clk_in) begin
		rst_seen_r <= !resetn_in;
		if (resetn_in && rst_seen_r) begin
			init_drv_en_out <= init_drv_strap_in;
			init_obs_en_out <= init_obs_strap_in;
			agent_id_out <= bus_req_strap_in ? AGENT_ID_ZERO
				: AGENT_ID_OTHER;
		end else if (!resetn_in) begin
			init_drv_en_out <= 1'b0;
			init_obs_en_out <= 1'b0;
			agent_id_out <= AGENT_ID_ZERO;
		end
	end
endmodule

// File: rtl/event_irq.sv
// Sticky event status with mask and read clear
`timescale 1ns/1ps
module event_irq
	import bus_arb_pkg::*;
#(
	parameter int W = EV_WIDTH
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic [W-1:0] event_in,
	input wire logic clear_in,
	input wire logic mask_we_in,
	input wire logic [W-1:0] mask_in,
	output logic [W-1:0] status_out,
	output logic [W-1:0] mask_out,
	output logic irq_out
);
	wire [W-1:0] status_nxt;
	// Set wins over read clear
	assign status_nxt = (clear_in ? '0 : status_out) | event_in;
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			status_out <= '0;
			mask_out <= '0;
			irq_out <= 1'b0;
		end else begin
			status_out <= status_nxt;
			if (mask_we_in)
				mask_out <= mask_in;
			irq_out <= |(status_nxt & (mask_we_in ? mask_in : mask_out));
		end
	end
endmodule

// File: bench/bus_arb_assertions.sv
// Port checker for the arbitration control block
`timescale 1ns/1ps
module bus_arb_assertions
	import bus_arb_pkg::*;
#(
	parameter logic [1:0] FREQ_CODE = FREQ_SEL_100MHZ
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic init_drv_strap_in,
	input wire logic init_obs_strap_in,
	input wire logic bus_init_line_in,
	input wire logic bus_init_line_oe_out,
	input wire logic block_next_request_in,
	input wire logic block_next_request_oe_out,
	input wire logic priority_bus_request_in,
	input wire logic bus_request_in,
	input wire logic probe_request_in,
	input wire logic debug_req_out,
	input wire logic issue_ok_out,
	input wire logic [1:0] clock_freq_select_out,
	input wire logic [1:0] agent_id_out
);
	logic [1:0] up_r;
	logic [1:0] id_r;
	logic drv_r;
	logic obs_r;
	logic lk_r;
	wire ctl_wr = reg_wr_in && reg_addr_in == REG_CTRL;
	// Straps at first edge after release, lock bit from writes
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			up_r <= 2'h0;
			lk_r <= 1'b0;
		end else begin
			up_r <= (up_r == 2'h3) ? up_r : up_r + 2'h1;
			// Observed bus init clears the lock bit, even over a write
			if (bus_init_line_in && obs_r && up_r != 2'h0)
				lk_r <= 1'b0;
			else if (ctl_wr)
				lk_r <= reg_wdata_in[CTRL_LOCKED];
		end
		if (resetn_in && up_r == 2'h0) begin
			drv_r <= init_drv_strap_in;
			obs_r <= init_obs_strap_in;
			id_r <= bus_request_in ? AGENT_ID_ZERO : AGENT_ID_OTHER;
		end
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	a_freq_fixed: assert property (
		clock_freq_select_out == FREQ_CODE)
		else $error("frequency select code moved");
	a_stall_halts: assert property (
		block_next_request_in |=> !issue_ok_out)
		else $error("issue allowed during stall");
	a_pri_halts: assert property (
		priority_bus_request_in && !lk_r |=> !issue_ok_out)
		else $error("issue allowed under priority request");
	a_init_halts: assert property (
		bus_init_line_in && obs_r && up_r[1] |=> !issue_ok_out)
		else $error("issue allowed during bus init");
	a_init_quiet: assert property (
		!drv_r && up_r[1] |-> !bus_init_line_oe_out)
		else $error("bus init driven while disabled");
	a_fault_drives: assert property (
		ctl_wr && reg_wdata_in[CTRL_FAULT] && drv_r && up_r[1]
		|-> ##[1:2] bus_init_line_oe_out)
		else $error("fault did not drive bus init");
	a_stall_drives: assert property (
		ctl_wr && reg_wdata_in[CTRL_STALL]
		|-> ##[1:2] block_next_request_oe_out)
		else $error("stall bit did not drive line");
	a_probe_echo: assert property (
		$rose(probe_request_in) |=> debug_req_out)
		else $error("probe request not passed on");
	a_agent_id: assert property (
		up_r == 2'h3 |-> agent_id_out == id_r)
		else $error("agent id not from strap");
	c_pri: cover property (priority_bus_request_in ##1 !issue_ok_out);
	c_init: cover property (bus_init_line_in && obs_r);
	c_own: cover property ($rose(issue_ok_out));
endmodule
bind system_bus_arbitration_control bus_arb_assertions
	#(.FREQ_CODE(FREQ_CODE)) i_chk (.ref_clk_in, .resetn_in,
	.reg_addr_in, .reg_wdata_in, .reg_wr_in, .init_drv_strap_in,
	.init_obs_strap_in, .bus_init_line_in, .bus_init_line_oe_out,
	.block_next_request_in, .block_next_request_oe_out,
	.priority_bus_request_in, .bus_request_in, .probe_request_in,
	.debug_req_out, .issue_ok_out, .clock_freq_select_out,
	.agent_id_out);

// File: bench/bus_agents_model.sv
// Far-side agents: priority agent, init and stall sources
`timescale 1ns/1ps
module bus_agents_model (
	input wire logic ref_clk_in,
	input wire logic [3:0] pri_len_in,
	input wire logic init_go_in,
	input wire logic stall_in,
	input wire logic dut_init_in,
	input wire logic dut_init_oe_in,
	input wire logic dut_bnr_in,
	input wire logic dut_bnr_oe_in,
	output logic priority_bus_request_out,
	output logic bus_init_level_out,
	output logic bnr_level_out
);
	logic [3:0] left_r = 4'h0;
	// Priority agent keeps its request until its transfers end
	always_ff @(posedge ref_clk_in) begin
		left_r <= (left_r != 4'h0) ? left_r - 4'h1 : pri_len_in;
	end
	assign priority_bus_request_out = left_r != 4'h0;
	// Shared lines: any agent may assert
	assign bus_init_level_out = init_go_in | (dut_init_oe_in & dut_init_in);
	assign bnr_level_out = stall_in | (dut_bnr_oe_in & dut_bnr_in);
endmodule

// File: bench/system_bus_arbitration_control_tb.sv
// Self-checking bench for the arbitration control block
`timescale 1ns/1ps
module system_bus_arbitration_control_tb;
	import bus_arb_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wd = 32'h0000_0000;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [3:0] mon = 4'h0;
	logic probe_request = 1'b0;
	logic [3:0] pri_len = 4'h0;
	logic init_go = 1'b0;
	logic stall = 1'b0;
	logic drv_s = 1'b1;
	logic obs_s = 1'b1;
	logic [31:0] rdata;
	logic init_o, init_oe, bnr_o, bnr_oe, breq_o, breq_oe, pri, init_l, bnr_l;
	logic probe_ready, dbg, ok, irq;
	logic [3:0] bpm;
	logic [1:0] fsel, aid;
	int n_mismatch = 0;
	int samples_checked = 0;
	wire breq_l = breq_oe ? breq_o : 1'b1; // Pull-up on request pin
	system_bus_arbitration_control i_dut (.ref_clk_in(clk), .resetn_in(rstn),
		.reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr_s),
		.reg_rd_in(rd_s), .reg_rdata_out(rdata), .init_drv_strap_in(drv_s),
		.init_obs_strap_in(obs_s), .bus_init_line_in(init_l),
		.bus_init_line_out(init_o), .bus_init_line_oe_out(init_oe),
		.block_next_request_in(bnr_l), .block_next_request_out(bnr_o),
		.block_next_request_oe_out(bnr_oe), .priority_bus_request_in(pri),
		.bus_request_in(breq_l), .bus_request_out(breq_o),
		.bus_request_oe_out(breq_oe), .mon_status_in(mon),
		.breakpoint_monitor_lines_out(bpm), .probe_ready_out(probe_ready),
		.probe_request_in(probe_request), .debug_req_out(dbg), .issue_ok_out(ok),
		.clock_freq_select_out(fsel), .agent_id_out(aid), .irq_out(irq));
	bus_agents_model i_far (.ref_clk_in(clk), .pri_len_in(pri_len),
		.init_go_in(init_go), .stall_in(stall), .dut_init_in(init_o),
		.dut_init_oe_in(init_oe), .dut_bnr_in(bnr_o), .dut_bnr_oe_in(bnr_oe),
		.priority_bus_request_out(pri), .bus_init_level_out(init_l),
		.bnr_level_out(bnr_l));
	initial forever #5 clk = ~clk;
	task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		samples_checked++;
		if (v !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, e, v);
		end
	endtask
	task settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e, input string nm);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk(nm, e, rdata);
	endtask
	task wait_ok(input logic v);
		// Look only after the edge has settled, never at it
		settle(1);
		for (int i = 0; i < 32 && ok !== v; i++) settle(1);
		chk("issue_ok", {31'h0, v}, {31'h0, ok});
	endtask
	task close_out;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		settle(4);
		chk("agent_id", AGENT_ID_ZERO, aid);
		chk("freq_sel", FREQ_SEL_100MHZ, fsel);
		rd(REG_STATUS, 32'h0000_000c, "status");
		rd(REG_CONFIG, FREQ_SEL_100MHZ, "config");
		rd(4'hf, 32'h0000_0000, "unmapped");
		chk("bus_request_idle", 32'h0000_0000, breq_oe);
		$display("test config done");
		wr(REG_CTRL, 32'h0000_0001);
		wait_ok(1'b1);
		chk("bus_request", 32'h0000_0001, breq_o);
		chk("bus_request_oe", 32'h0000_0001, breq_oe);
		@(posedge clk);
		stall <= 1'b1;
		settle(2);
		chk("issue_stall", 32'h0000_0000, ok);
		stall <= 1'b0;
		wait_ok(1'b1);
		wr(REG_CTRL, 32'h0000_0009);
		settle(2);
		chk("bnr_oe", 32'h0000_0001, bnr_oe);
		chk("bnr_out", 32'h0000_0001, bnr_o);
		wr(REG_CTRL, 32'h0000_0001);
		wait_ok(1'b1);
		$display("test stall done");
		// Mask bits enable their status bits onto the interrupt
		wr(REG_IRQ_MASK, 32'h0000_0007);
		@(posedge clk);
		pri_len <= 4'h6;
		@(posedge clk);
		pri_len <= 4'h0;
		settle(2);
		chk("issue_pri", 32'h0000_0000, ok);
		chk("irq", 32'h0000_0001, irq);
		wait_ok(1'b1);
		rd(REG_IRQ_STAT, 32'h0000_0002, "irq_stat");
		settle(1);
		chk("irq_clr", 32'h0000_0000, irq);
		wr(REG_CTRL, 32'h0000_0003);
		@(posedge clk);
		pri_len <= 4'h6;
		@(posedge clk);
		pri_len <= 4'h0;
		settle(3);
		chk("issue_lock", 32'h0000_0001, ok);
		$display("test priority done");
		settle(8);
		init_go <= 1'b1;
		@(posedge clk);
		init_go <= 1'b0;
		settle(1);
		chk("issue_init", 32'h0000_0000, ok);
		rd(REG_CTRL, 32'h0000_0001, "ctrl_lock");
		wait_ok(1'b1);
		rd(REG_IRQ_STAT, 32'h0000_0003, "irq_stat");
		$display("test init done");
		wr(REG_IRQ_MASK, 32'h0000_0000);
		@(posedge clk);
		probe_request <= 1'b1;
		mon <= 4'ha;
		settle(2);
		chk("debug_req", 32'h0000_0001, dbg);
		chk("bpm", 32'h0000_000a, bpm);
		chk("irq_mask", 32'h0000_0000, irq);
		rd(REG_IRQ_STAT, 32'h0000_0004, "irq_stat");
		rd(REG_MONITOR, 32'h0000_000a, "monitor");
		probe_request <= 1'b0;
		wr(REG_CTRL, 32'h0000_0015);
		settle(2);
		chk("probe_ready", 32'h0000_0001, probe_ready);
		chk("init_oe", 32'h0000_0001, init_oe);
		chk("init_out", 32'h0000_0001, init_o);
		wr(REG_CTRL, 32'h0000_0001);
		wait_ok(1'b1);
		$display("test debug done");
		// Second reset with both bus init straps off
		rstn <= 1'b0;
		drv_s <= 1'b0;
		obs_s <= 1'b0;
		settle(16);
		rstn <= 1'b1;
		settle(4);
		rd(REG_STATUS, 32'h0000_0000, "status_off");
		wr(REG_CTRL, 32'h0000_0005);
		wait_ok(1'b1);
		chk("init_oe_off", 32'h0000_0000, init_oe);
		init_go <= 1'b1;
		settle(2);
		chk("issue_no_obs", 32'h0000_0001, ok);
		rd(REG_IRQ_STAT, 32'h0000_0000, "irq_off");
		init_go <= 1'b0;
		$display("test straps off done");
		close_out();
	end
endmodule
